//--- verification/wide_timer_capture_compare_pwm_test.sv
// self-checking bench for the wide timer
`timescale 1ns/1ps
module wide_timer_capture_compare_pwm_test
    import wt_pkg::*;
;
    logic i_clk, i_nrst, avs_rd, avs_wr, cnt_evt, irq, wait_rq, ovf, ce;
    logic [5:0] avs_addr;
    logic [31:0] avs_wd, avs_q, q, b, a, v, c;
    logic [NCH-1:0] cc_in, cc_out, cc_outn, rfx_cc;
    logic [7:0] n_cc, n_ovf;
    logic [5:0] ofs [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20,
        6'h24, 6'h28, 6'h2C, 6'h3C};
    int num_errors = 0;
    int n_tests = 0;
    int seed = 32'h45712298;
    int n;

    wt_timer uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce),
        .i_avs_address(avs_addr), .i_avs_read(avs_rd),
        .i_avs_write(avs_wr), .i_avs_writedata(avs_wd),
        .i_avs_byteenable(4'hF), .o_avs_readdata(avs_q),
        .o_avs_waitrequest(wait_rq), .i_cc_in(cc_in), .i_cnt_evt(cnt_evt),
        .o_cc_out(cc_out), .o_cc_outn(cc_outn), .o_reflex_cc(rfx_cc),
        .o_reflex_ovf(ovf), .o_irq(irq));
    wt_reflex_sink sink (.i_clk(i_clk), .i_nrst(i_nrst), .i_cc(rfx_cc),
        .i_ovf(ovf), .o_n_cc(n_cc), .o_n_ovf(n_ovf));

    // clock generation, 20 ns period
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // verdict and end of run
    task automatic conclude();
        if (num_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // compare one value against its expectation
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk);
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] ad,
        input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge i_clk);
        avs_addr <= ad;
        avs_wd <= d;
        avs_rd <= !w;
        avs_wr <= w;
        for (k = 0; k < 50; k++)
        begin
            @(posedge i_clk);
            if (wait_rq === 1'b0)
                break;
        end
        r = avs_q;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
        if (k == 50)
        begin
            num_errors++;
            conclude();
        end
    endtask

    task automatic wr(input logic [5:0] ad, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, ad, d, r);
    endtask

    task automatic rdchk(input string nm, input logic [5:0] ad,
        input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, ad, 32'h00000000, r);
        chk(nm, r, e);
    endtask

    // main sequence
    initial
    begin
        i_nrst = 1'b0;
        ce = 1'b1;
        avs_rd = 1'b0;
        avs_wr = 1'b0;
        avs_addr = 6'h00;
        avs_wd = 32'h00000000;
        cc_in = 4'h0;
        cnt_evt = 1'b0;
        cyc(4);
        i_nrst <= 1'b1;
        // reset values, four channel slots and an unmapped word
        foreach (ofs[i])
            rdchk("reset value", ofs[i], 32'h00000000);
        // counter holds any 32-bit value written
        repeat (4)
        begin
            v = $random(seed);
            wr(OFS_CNT, v);
            rdchk("cnt", OFS_CNT, v);
        end
        // wrap sets overflow, irq follows mask and clear
        wr(OFS_MASK, 32'h00000001);
        wr(OFS_CNT, 32'hFFFFFFF0);
        wr(OFS_CTRL, 32'h00000001);
        cyc(30);
        rdchk("stat ovf", OFS_STAT, 32'h00000001);
        chk("ovf pulses", n_ovf, 32'h1);
        chk("irq set", irq, 1'b1);
        wr(OFS_MASK, 32'h00000000);
        cyc(3);
        chk("irq masked", irq, 1'b0);
        wr(OFS_MASK, 32'h00000001);
        wr(OFS_STAT, 32'h00000001);
        cyc(3);
        chk("irq cleared", irq, 1'b0);
        // capture on rising then falling edge of channel 0
        wr(OFS_CCCFG, 32'h00000001);
        bus(1'b0, OFS_CNT, 32'h0, b);
        cc_in <= 4'h1;
        cyc(8);
        bus(1'b0, OFS_CNT, 32'h0, a);
        bus(1'b0, OFS_CC0, 32'h0, c);
        chk("capture window", (c >= b) && (c <= a), 1'b1);
        rdchk("stat cap", OFS_STAT, 32'h00000002);
        chk("cc pulses", n_cc, 32'h1);
        wr(OFS_STAT, 32'h00000002);
        wr(OFS_CCCFG, 32'h00000005);
        cc_in <= 4'h0;
        cyc(8);
        rdchk("stat fall", OFS_STAT, 32'h00000002);
        // compare on channel 1 with the counter stopped
        wr(OFS_CTRL, 32'h00000000);
        wr(OFS_CCCFG, 32'h00000020);
        repeat (6)
        begin
            v = $random(seed);
            c = $random(seed);
            wr(OFS_CNT, v);
            wr(6'h24, c);
            cyc(3);
            chk("cmp out", cc_out[1], v >= c);
        end
        wr(OFS_CCCFG, 32'h00000000);
        cyc(3);
        chk("off out", cc_out[1], 1'b0);
        // pwm on channel 2: new value waits for the wrap
        wr(OFS_CNT, 32'h0000000A);
        wr(6'h28, 32'h00000014);
        wr(OFS_CCCFG, 32'h00000300);
        cyc(3);
        chk("pwm out", cc_out[2], 1'b1);
        wr(6'h28, 32'h000003E8);
        wr(OFS_CNT, 32'hFFFFFFFE);
        wr(OFS_CTRL, 32'h00000001);
        cyc(30);
        chk("pwm reload", cc_out[2], 1'b1);
        // dead time of 5 cycles on channel 1 of instance 0
        wr(OFS_CTRL, 32'h00000504);
        wr(OFS_CCCFG, 32'h00000020);
        wr(OFS_CNT, 32'h00000064);
        wr(6'h24, 32'h000000C8);
        cyc(12);
        chk("pair low", {cc_out[1], cc_outn[1]}, 2'b01);
        wr(6'h24, 32'h00000032);
        n = 0;
        repeat (40)
        begin
            @(posedge i_clk);
            if (cc_out[1] === 1'b0 && cc_outn[1] === 1'b0)
                n++;
        end
        chk("dead cycles", n, 32'h5);
        chk("pair high", {cc_out[1], cc_outn[1]}, 2'b10);
        // external events advance the counter one by one
        wr(OFS_CCCFG, 32'h00000000);
        wr(OFS_CNT, 32'h00000000);
        wr(OFS_CTRL, 32'h00000003);
        repeat (3)
        begin
            cnt_evt <= 1'b1;
            cyc(2);
            cnt_evt <= 1'b0;
            cyc(2);
        end
        cyc(6);
        rdchk("event count", OFS_CNT, 32'h00000003);
        // clock enable low for 20 cycles loses exactly 20 ticks
        wr(OFS_CTRL, 32'h00000001);
        bus(1'b0, OFS_CNT, 32'h0, a);
        bus(1'b0, OFS_CNT, 32'h0, b);
        v = b - a;
        bus(1'b0, OFS_CNT, 32'h0, a);
        ce <= 1'b0;
        cyc(20);
        ce <= 1'b1;
        bus(1'b0, OFS_CNT, 32'h0, b);
        chk("ce freeze", b - a, v);
        conclude();
    end
endmodule

//--- verification/wt_reflex_sink.sv
// reflex network consumer model: counts event pulses from the timer
`timescale 1ns/1ps
module wt_reflex_sink
    import wt_pkg::*;
(
    input wire logic i_clk, // functional clock
    input wire logic i_nrst, // async reset, active low
    input wire logic [NCH-1:0] i_cc, // channel event pulses
    input wire logic i_ovf, // counter wrap pulse
    output logic [7:0] o_n_cc, // channel pulses seen
    output logic [7:0] o_n_ovf // wrap pulses seen
);
    // each wrap pulse and each cycle with any channel pulse starts one action here, no software involved
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_n_cc <= 8'h00;
            o_n_ovf <= 8'h00;
        end
        else
        begin
            o_n_cc <= o_n_cc + 8'(i_cc != '0);
            o_n_ovf <= o_n_ovf + 8'(i_ovf);
        end
    end
endmodule

//--- verilog/wt_chan.sv
// one capture/compare/pwm channel with optional dead-time pair
`timescale 1ns/1ps
module wt_chan
    import wt_pkg::*;
#(
    parameter bit HAS_DT = 1'b1 // dead-time logic present
)
(
    input wire logic i_clk, // functional clock
    input wire logic i_nrst, // async reset, active low
    input wire logic i_ce, // clock enable
    input wire wt_mode_e i_mode, // channel mode
    input wire logic [31:0] i_cnt, // shared counter value
    input wire logic i_tick, // counter advances this cycle
    input wire logic i_wrap, // counter wraps this cycle
    input wire logic i_evt, // selected capture edge
    input wire logic i_wr, // software writes the value
    input wire logic [31:0] i_wdata, // merged write word
    input wire logic i_dt_en, // dead time requested
    input wire logic [DT_W-1:0] i_dt_len, // dead-time cycles
    output logic [31:0] o_val, // capture or compare value
    output logic o_out, // channel output
    output logic o_outn, // complementary output
    output logic o_hit // capture, match or pwm wrap event
);
    logic [31:0] val_ff, nxt_val, buf_ff, nxt_buf;
    logic lvl_ff, nxt_lvl, out_ff, nxt_out, outn_ff, nxt_outn;
    logic [DT_W-1:0] dt_ff, nxt_dt;
    logic raw, hit, use_dt, gap;

    // mode behaviour: capture, compare or pwm
    always_comb
    begin
        nxt_val = val_ff;
        nxt_buf = buf_ff;
        raw = 1'b0;
        hit = 1'b0;
        case (i_mode) // (RL3)
            WT_CAP:
            begin
                if (i_evt)
                begin
                    nxt_val = i_cnt; // (RL4)
                    hit = 1'b1;
                end
            end
            WT_CMP:
            begin
                raw = (i_cnt >= val_ff); // (RL5)
                hit = i_tick && (i_cnt == val_ff);
            end
            WT_PWM:
            begin
                raw = (i_cnt < val_ff);
                hit = i_wrap;
                if (i_wrap)
                    nxt_val = buf_ff; // (RL6)
            end
            default:
            begin
                raw = 1'b0;
            end
        endcase
        if (i_wr)
        begin
            nxt_buf = i_wdata;
            if (i_mode != WT_PWM)
                nxt_val = i_wdata;
        end
    end

    // dead time: both outputs low for i_dt_len cycles after a change
    always_comb
    begin
        use_dt = HAS_DT && i_dt_en; // (RL7)
        nxt_lvl = raw;
        nxt_dt = DT_RST;
        if (use_dt)
        begin
            if (raw != lvl_ff)
                nxt_dt = i_dt_len; // (RL10)
            else if (dt_ff != DT_RST)
                nxt_dt = dt_ff - 8'h01;
        end
        gap = use_dt && (nxt_dt != DT_RST);
        nxt_out = raw && !gap;
        nxt_outn = use_dt && !raw && !gap; // (RL10)
    end

    // state registers
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            val_ff <= CC_RST;
            buf_ff <= CC_RST;
            lvl_ff <= 1'b0;
            out_ff <= 1'b0;
            outn_ff <= 1'b0;
            dt_ff <= DT_RST;
        end
        else if (i_ce)
        begin
            val_ff <= nxt_val;
            buf_ff <= nxt_buf;
            lvl_ff <= nxt_lvl;
            out_ff <= nxt_out;
            outn_ff <= nxt_outn;
            dt_ff <= nxt_dt;
        end
    end

    assign o_val = val_ff;
    assign o_out = out_ff;
    assign o_outn = outn_ff;
    assign o_hit = hit;

    cap_load_a: assert property ( // (RL4)
        @(posedge i_clk) disable iff (!i_nrst)
        i_ce && i_mode == WT_CAP && i_evt && !i_wr
        |=> val_ff == $past(i_cnt))
        else $error("capture did not store the counter");
    cmp_out_a: assert property ( // (RL5)
        @(posedge i_clk) disable iff (!i_nrst)
        i_ce && i_mode == WT_CMP && !use_dt
        |=> out_ff == ($past(i_cnt) >= $past(val_ff)))
        else $error("compare output wrong");
    pwm_load_a: assert property ( // (RL6)
        @(posedge i_clk) disable iff (!i_nrst)
        i_ce && i_mode == WT_PWM && i_wrap && !i_wr
        |=> val_ff == $past(buf_ff))
        else $error("pwm value not reloaded at wrap");
    cmp_hold_a: assert property ( // (RL3)
        @(posedge i_clk) disable iff (!i_nrst)
        i_ce && i_mode == WT_CMP && !i_wr |=> $stable(val_ff))
        else $error("compare value changed without a write");
    dt_gap_a: assert property ( // (RL10)
        @(posedge i_clk) disable iff (!i_nrst)
        i_ce && use_dt && raw != lvl_ff && i_dt_len != DT_RST
        |=> !out_ff && !outn_ff)
        else $error("no dead time at transition");
    pair_excl_a: assert property ( // (RL10)
        @(posedge i_clk) disable iff (!i_nrst)
        !(out_ff && outn_ff))
        else $error("both outputs of a pair active");
endmodule

//--- verilog/wt_pkg.sv
// package: register map, field positions, reset values and channel modes
package wt_pkg;
    localparam int unsigned NCH = 4;
    localparam logic [31:0] CNT_MAX = 32'hFFFFFFFF;
    // register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_CNT = 6'h04;
    localparam logic [5:0] OFS_STAT = 6'h08;
    localparam logic [5:0] OFS_MASK = 6'h0C;
    localparam logic [5:0] OFS_CCCFG = 6'h10;
    localparam logic [5:0] OFS_CC0 = 6'h20;
    localparam logic [5:0] CC_STRIDE = 6'h04;
    // control fields
    localparam int unsigned CTRL_RUN = 0;
    localparam int unsigned CTRL_EXTCNT = 1;
    localparam int unsigned CTRL_DTEN = 2;
    localparam int unsigned CTRL_DTLO = 8;
    localparam int unsigned DT_W = 8;
    // status and mask fields
    localparam int unsigned STAT_OVF = 0;
    localparam int unsigned STAT_CC0 = 1;
    localparam int unsigned STAT_W = 5;
    // channel config: 4 bits a channel, mode in [1:0], falling edge in [2]
    localparam int unsigned CFG_STRIDE = 4;
    localparam int unsigned CFG_FALL = 2;
    localparam int unsigned CFG_W = 16;
    // values after reset
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [31:0] CNT_RST = 32'h00000000;
    localparam logic [4:0] STAT_RST = 5'h00;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [31:0] CC_RST = 32'h00000000;
    localparam logic [DT_W-1:0] DT_RST = 8'h00;

    typedef enum logic [1:0] {
        WT_OFF = 2'b00,
        WT_CAP = 2'b01,
        WT_CMP = 2'b10,
        WT_PWM = 2'b11
    } wt_mode_e;

    // byte-lane merge of a bus write into an old word
    function automatic logic [31:0] wt_merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                r[8*b +: 8] = wd[8*b +: 8];
        end
        return r;
    endfunction
endpackage

//--- verilog/wt_timer.sv
// wide timer: 32-bit counter, four channels, avalon-mm slave, interrupt
`timescale 1ns/1ps
// Functional notes
// (RL1) One 32-bit counter serves both for timing and for event counting.
// (RL2) Four capture/compare channels all work on that one counter value.
// (RL3) Each channel runs in exactly one of off, capture, compare or pwm mode.
// (RL4) In capture mode the selected input edge copies the counter to the channel.
// (RL5) In compare mode the output shows whether the counter reached the value.
// (RL6) In pwm mode a value written to the channel takes effect at the next counter wrap.
// (RL7) Dead-time insertion exists in instance 0 only.
// (RL8) Counter wrap and channel events drive pulses onto the reflex network.
// (RL9) The running counter steps by one per count event and wraps to zero, flagging overflow.
// (RL10) With dead time on, each channel drives a complementary pair kept low around transitions.
module wt_timer
    import wt_pkg::*;
#(
    parameter int INST_ID = 0 // instance number
)
(
    input wire logic i_clk, // 50 MHz clock
    input wire logic i_nrst, // async reset, active low
    input wire logic i_ce, // clock enable, freezes all state
    input wire logic [5:0] i_avs_address, // byte address
    input wire logic i_avs_read, // read request
    input wire logic i_avs_write, // write request
    input wire logic [31:0] i_avs_writedata, // write data
    input wire logic [3:0] i_avs_byteenable, // write byte lanes
    output logic [31:0] o_avs_readdata, // read data
    output logic o_avs_waitrequest, // stall
    input wire logic [NCH-1:0] i_cc_in, // capture input pins
    input wire logic i_cnt_evt, // external count event pin
    output logic [NCH-1:0] o_cc_out, // channel outputs
    output logic [NCH-1:0] o_cc_outn, // complementary outputs
    output logic [NCH-1:0] o_reflex_cc, // channel event pulses
    output logic o_reflex_ovf, // counter wrap pulse
    output logic o_irq // level interrupt
);
    logic [31:0] ctrl_ff, nxt_ctrl, cnt_ff, nxt_cnt;
    logic [STAT_W-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
    logic [CFG_W-1:0] cfg_ff, nxt_cfg;
    logic wait_ff, nxt_wait;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [NCH:0] s1_ff, s2_ff, s3_ff, stab_ff, nxt_stab;
    logic [NCH:0] rise, fall;
    logic [NCH-1:0] refl_ff, nxt_refl, hit, cc_wr, evt, outp, outn;
    logic ovf_ff, nxt_ovf, irq_ff, nxt_irq;
    logic acc, wr_acc, cnt_wr, tick, wrap;
    logic [STAT_W-1:0] ev;
    logic [31:0] chan_val [NCH];

    // pin synchroniser; a level counts once stages two and three agree
    always_comb
    begin
        nxt_stab = (stab_ff & (s2_ff ^ s3_ff)) | (s3_ff & ~(s2_ff ^ s3_ff));
        rise = nxt_stab & ~stab_ff;
        fall = ~nxt_stab & stab_ff;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            stab_ff <= '0;
        end
        else if (i_ce)
        begin
            s1_ff <= {i_cnt_evt, i_cc_in};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            stab_ff <= nxt_stab;
        end
    end

    // bus handshake: one wait cycle, access completes when wait is low
    always_comb
    begin
        acc = (i_avs_read || i_avs_write) && !wait_ff;
        wr_acc = acc && i_avs_write;
        nxt_wait = !((i_avs_read || i_avs_write) && wait_ff);
        cnt_wr = wr_acc && (i_avs_address == OFS_CNT);
    end

    // count events and wrap
    always_comb
    begin
        tick = ctrl_ff[CTRL_RUN] &&
            (!ctrl_ff[CTRL_EXTCNT] || rise[NCH]); // (RL9)
        wrap = tick && (cnt_ff == CNT_MAX) && !cnt_wr; // (RL9)
        for (int k = 0; k < NCH; k++)
        begin
            evt[k] = cfg_ff[CFG_STRIDE*k + CFG_FALL] ? fall[k] : rise[k];
            cc_wr[k] = wr_acc &&
                (i_avs_address == OFS_CC0 + 6'(k) * CC_STRIDE);
        end
        ev = {hit, wrap};
    end

    // register file next values; a set beats a same-cycle clear
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_cfg = cfg_ff;
        nxt_mask = mask_ff;
        nxt_cnt = cnt_ff;
        nxt_stat = stat_ff | ev; // (RL9)
        if (tick)
            nxt_cnt = cnt_ff + 32'h00000001; // (RL1)
        if (wr_acc)
        begin
            case (i_avs_address)
                OFS_CTRL: nxt_ctrl = wt_merge(ctrl_ff, i_avs_writedata,
                    i_avs_byteenable);
                OFS_CNT: nxt_cnt = wt_merge(cnt_ff, i_avs_writedata,
                    i_avs_byteenable);
                OFS_STAT: nxt_stat = (stat_ff &
                    ~i_avs_writedata[STAT_W-1:0]) | ev;
                OFS_MASK: nxt_mask = i_avs_writedata[STAT_W-1:0];
                OFS_CCCFG: nxt_cfg = i_avs_writedata[CFG_W-1:0];
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
    end

    // read data, loaded while wait is high so it stands when wait drops
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (i_avs_read && wait_ff)
        begin
            case (i_avs_address)
                OFS_CTRL: nxt_rdata = ctrl_ff;
                OFS_CNT: nxt_rdata = cnt_ff;
                OFS_STAT: nxt_rdata = {27'h0000000, stat_ff};
                OFS_MASK: nxt_rdata = {27'h0000000, mask_ff};
                OFS_CCCFG: nxt_rdata = {16'h0000, cfg_ff};
                default: nxt_rdata = 32'h00000000;
            endcase
            for (int k = 0; k < NCH; k++)
            begin
                if (i_avs_address == OFS_CC0 + 6'(k) * CC_STRIDE)
                    nxt_rdata = chan_val[k];
            end
        end
    end

    // reflex pulses and interrupt level
    always_comb
    begin
        nxt_refl = hit; // (RL8)
        nxt_ovf = wrap; // (RL8)
        nxt_irq = |(nxt_stat & nxt_mask);
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ctrl_ff <= CTRL_RST;
            cnt_ff <= CNT_RST;
            stat_ff <= STAT_RST;
            mask_ff <= STAT_RST;
            cfg_ff <= CFG_RST;
            wait_ff <= 1'b1;
            rdata_ff <= 32'h00000000;
            refl_ff <= '0;
            ovf_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else if (i_ce)
        begin
            ctrl_ff <= nxt_ctrl;
            cnt_ff <= nxt_cnt;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            cfg_ff <= nxt_cfg;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
            refl_ff <= nxt_refl;
            ovf_ff <= nxt_ovf;
            irq_ff <= nxt_irq;
        end
    end

    // four channels on the shared counter
    for (genvar gi = 0; gi < NCH; gi++)
    begin : g_ch
        wt_chan #(
            .HAS_DT(INST_ID == 0) // (RL7)
        ) u_ch (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_ce(i_ce),
            .i_mode(wt_mode_e'(cfg_ff[CFG_STRIDE*gi +: 2])),
            .i_cnt(cnt_ff), // (RL2)
            .i_tick(tick),
            .i_wrap(wrap),
            .i_evt(evt[gi]),
            .i_wr(cc_wr[gi]),
            .i_wdata(wt_merge(chan_val[gi], i_avs_writedata,
                i_avs_byteenable)),
            .i_dt_en(ctrl_ff[CTRL_DTEN]),
            .i_dt_len(ctrl_ff[CTRL_DTLO +: DT_W]),
            .o_val(chan_val[gi]),
            .o_out(outp[gi]),
            .o_outn(outn[gi]),
            .o_hit(hit[gi])
        );
    end

    assign o_avs_readdata = rdata_ff;
    assign o_avs_waitrequest = wait_ff;
    assign o_cc_out = outp;
    assign o_cc_outn = outn;
    assign o_reflex_cc = refl_ff;
    assign o_reflex_ovf = ovf_ff;
    assign o_irq = irq_ff;

    cnt_step_a: assert property ( // (RL1)
        @(posedge i_clk) disable iff (!i_nrst)
        i_ce && tick && !cnt_wr |=> cnt_ff == $past(cnt_ff) + 32'h00000001)
        else $error("counter did not step by one");
    ovf_flag_a: assert property ( // (RL9)
        @(posedge i_clk) disable iff (!i_nrst)
        i_ce && wrap |=> stat_ff[STAT_OVF] && cnt_ff == CNT_RST)
        else $error("wrap did not flag overflow");
    reflex_ovf_a: assert property ( // (RL8)
        @(posedge i_clk) disable iff (!i_nrst)
        i_ce && wrap |=> o_reflex_ovf)
        else $error("no reflex pulse on wrap");
    chan_hit_a: assert property ( // (RL8)
        @(posedge i_clk) disable iff (!i_nrst)
        i_ce |=> o_reflex_cc == $past(hit))
        else $error("channel event not on reflex output");
    // a frozen clock enable must hold counter and flags
    ce_freeze_a: assert property ( // (RL1)
        @(posedge i_clk) disable iff (!i_nrst)
        !i_ce |=> $stable(cnt_ff) && $stable(stat_ff))
        else $error("state moved while clock enable low");
    // overflow flag stays until software writes a one to it
    ovf_sticky_a: assert property ( // (RL9)
        @(posedge i_clk) disable iff (!i_nrst)
        i_ce && stat_ff[STAT_OVF]
        && !(wr_acc && i_avs_address == OFS_STAT
        && i_avs_writedata[STAT_OVF])
        |=> stat_ff[STAT_OVF])
        else $error("overflow flag lost without a clear");
    // interrupt level mirrors the unmasked flags
    irq_level_a: assert property ( // (RL9)
        @(posedge i_clk) disable iff (!i_nrst)
        o_irq == |(stat_ff & mask_ff))
        else $error("interrupt level does not match flags");
    no_dt_a: assert property ( // (RL7)
        @(posedge i_clk) disable iff (!i_nrst)
        INST_ID != 0 |-> o_cc_outn == 4'h0)
        else $error("dead-time pair active outside instance 0");
endmodule
